// *** lsec_counter.sv ***
`timescale 1ns/10ps
`default_nettype none
module lsec_counter
  import lsec_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sel,
  input wire logic disp_err,
  input wire logic dec_err,
  input wire logic clr,
  output logic [15:0] count
);

  logic hit;

  // Pick the error type to count
  assign hit = sel ? dec_err : disp_err;

  // Saturating count, an error in the clearing cycle counts as one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= LSEC_CNT_RST;
    end else if (clr) begin
      count <= hit ? 16'h0001 : LSEC_CNT_RST;
    end else if (hit && count != LSEC_CNT_MAX) begin
      count <= count + 16'h0001;
    end
  end

endmodule
`default_nettype wire

// *** lsec_flag.sv ***
`timescale 1ns/10ps
`default_nettype none
module lsec_flag
  import lsec_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic set,
  input wire logic clr,
  output logic q
);

  // Sticky flag, set beats clear-on-read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// *** lsec_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module lsec_host
  import lsec_pkg::*;
(
  input wire logic core_clk,
  output var lsec_req_t req
);
  // One request word per cycle, changed just after an edge
  initial req = '0;
  task automatic put(input logic r, input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    req <= '{rd: r, wr: w, addr: a, wdata: d};
  endtask
endmodule
`default_nettype wire

// *** lsec_pkg.sv ***
package lsec_pkg;

  // Register addresses on the management port
  localparam logic [4:0] LSEC_ADDR_CHAN_STATUS = 5'h16;
  localparam logic [4:0] LSEC_ADDR_SYNC_STATUS = 5'h17;
  localparam logic [4:0] LSEC_ADDR_ERR_CTRL = 5'h19;
  localparam logic [4:0] LSEC_ADDR_CNT_A = 5'h1a;
  localparam logic [4:0] LSEC_ADDR_CNT_B = 5'h1b;
  localparam logic [4:0] LSEC_ADDR_CNT_C = 5'h1c;
  localparam logic [4:0] LSEC_ADDR_CNT_D = 5'h1d;

  // Field positions and lane count
  localparam int LSEC_ALIGN_BIT = 4;
  localparam int LSEC_COLL_LSB = 0;
  localparam int LSEC_DROP_LSB = 12;
  localparam int LSEC_INS_LSB = 8;
  localparam int LSEC_OVF_LSB = 4;
  localparam int LSEC_UNF_LSB = 0;
  localparam int LSEC_SEL_LSB = 0;
  localparam int LSEC_LANES = 4;

  // Reset values and the counter saturation value
  localparam logic [3:0] LSEC_SEL_RST = 4'h0;
  localparam logic [15:0] LSEC_CNT_RST = 16'h0000;
  localparam logic [15:0] LSEC_CNT_MAX = 16'hffff;

  // Datapath event strobes for one lane
  typedef struct packed {
    logic coll;
    logic drop_idle;
    logic ins_idle;
    logic ovf;
    logic unf;
    logic disp_err;
    logic dec_err;
  } lsec_lane_evt_t;

  // Management access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } lsec_req_t;

endpackage

// *** lsec_regs.sv ***
// Notes on behaviour
// - Reserved bits 15:5 of channel status and 15:4 of counter control read as zero.
// - Bit 4 of channel status is set when deskew realigns on the alignment character.
// - Bits 3..0 of channel status flag a receive FIFO collision reset on lanes D..A.
// - Every event flag in both status words clears when that word is read, except one whose event fires in the reading cycle.
// - Bits 15..12 of sync status flag a dropped idle column on lanes D..A.
// - Bits 11..8 of sync status flag an inserted idle column on lanes D..A.
// - Bits 7..4 of sync status flag an elastic FIFO overflow on lanes D..A.
// - Bits 3..0 of sync status flag an elastic FIFO underflow on lanes D..A.
// - Counter control bits 3..0 pick disparity (0, default) or decode (1) errors per lane.
// - Lane A's 16-bit error count reads at its register, counting its selected type.
// - Reading a counter register resets that counter to zero, or to one if its selected error arrives in the reading cycle.
// - Lanes B, C and D have matching clear-on-read counters at registers 27 to 29.
`timescale 1ns/10ps
`default_nettype none
module lsec_regs
  import lsec_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire lsec_req_t req,
  input wire lsec_lane_evt_t [3:0] lane_evt,
  input wire logic align_evt,
  output logic [15:0] rdata_r,
  output logic rvalid_r,
  output logic [3:0] cnt_sel_r
);

  logic [15:0] chan_status;
  logic [15:0] sync_status;
  logic [15:0] cnt [LSEC_LANES];
  logic clr_chan;
  logic clr_sync;
  logic [3:0] clr_cnt;
  logic [15:0] rdata_nxt;
  logic [3:0] cnt_sel_nxt;

  // Read strobe decode for one address
  function automatic logic rd_hit(input lsec_req_t r, input logic [4:0] a);
    rd_hit = r.rd && (r.addr == a);
  endfunction

  // Clear-on-read strobes
  assign clr_chan = rd_hit(req, LSEC_ADDR_CHAN_STATUS);
  assign clr_sync = rd_hit(req, LSEC_ADDR_SYNC_STATUS);
  assign clr_cnt[0] = rd_hit(req, LSEC_ADDR_CNT_A);
  assign clr_cnt[1] = rd_hit(req, LSEC_ADDR_CNT_B);
  assign clr_cnt[2] = rd_hit(req, LSEC_ADDR_CNT_C);
  assign clr_cnt[3] = rd_hit(req, LSEC_ADDR_CNT_D);

  // Reserved bits of channel status tie to zero
  assign chan_status[15:5] = 11'h000;

  // Alignment flag
  lsec_flag u_align (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .set(align_evt),
    .clr(clr_chan),
    .q(chan_status[LSEC_ALIGN_BIT])
  );

  // Per-lane flags and counters
  for (genvar i = 0; i < LSEC_LANES; i++) begin : g_lane
    lsec_flag u_coll (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .set(lane_evt[i].coll),
      .clr(clr_chan),
      .q(chan_status[LSEC_COLL_LSB + i])
    );
    lsec_flag u_drop (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .set(lane_evt[i].drop_idle),
      .clr(clr_sync),
      .q(sync_status[LSEC_DROP_LSB + i])
    );
    lsec_flag u_ins (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .set(lane_evt[i].ins_idle),
      .clr(clr_sync),
      .q(sync_status[LSEC_INS_LSB + i])
    );
    lsec_flag u_ovf (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .set(lane_evt[i].ovf),
      .clr(clr_sync),
      .q(sync_status[LSEC_OVF_LSB + i])
    );
    lsec_flag u_unf (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .set(lane_evt[i].unf),
      .clr(clr_sync),
      .q(sync_status[LSEC_UNF_LSB + i])
    );
    lsec_counter u_cnt (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .sel(cnt_sel_r[LSEC_SEL_LSB + i]),
      .disp_err(lane_evt[i].disp_err),
      .dec_err(lane_evt[i].dec_err),
      .clr(clr_cnt[i]),
      .count(cnt[i])
    );
  end

  // Counter select write
  always_comb begin
    cnt_sel_nxt = cnt_sel_r;
    if (req.wr && req.addr == LSEC_ADDR_ERR_CTRL) begin
      cnt_sel_nxt = req.wdata[3:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_sel_r <= LSEC_SEL_RST;
    end else begin
      cnt_sel_r <= cnt_sel_nxt;
    end
  end

  // Read mux, unmapped addresses read zero
  always_comb begin
    rdata_nxt = 16'h0000;
    case (req.addr)
      LSEC_ADDR_CHAN_STATUS: rdata_nxt = chan_status;
      LSEC_ADDR_SYNC_STATUS: rdata_nxt = sync_status;
      LSEC_ADDR_ERR_CTRL: rdata_nxt = {12'h000, cnt_sel_r};
      LSEC_ADDR_CNT_A: rdata_nxt = cnt[0];
      LSEC_ADDR_CNT_B: rdata_nxt = cnt[1];
      LSEC_ADDR_CNT_C: rdata_nxt = cnt[2];
      LSEC_ADDR_CNT_D: rdata_nxt = cnt[3];
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // Read data register, captured on the read strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= req.rd;
      if (req.rd) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

endmodule
`default_nettype wire

// *** lsec_regs_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module lsec_regs_chk
  import lsec_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire lsec_req_t req,
  input wire lsec_lane_evt_t [3:0] lane_evt,
  input wire logic align_evt,
  input wire logic [15:0] rdata_r,
  input wire logic rvalid_r,
  input wire logic [3:0] cnt_sel_r
);
  // Decoded reads and the channel status event sources
  wire logic rd_ch = req.rd && req.addr == LSEC_ADDR_CHAN_STATUS;
  wire logic rd_ca = req.rd && req.addr == LSEC_ADDR_CNT_A;
  wire logic ev_ch = align_evt | lane_evt[0].coll | lane_evt[1].coll | lane_evt[2].coll
    | lane_evt[3].coll;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_chan_resv: assert property (rd_ch |=> rdata_r[15:5] == 11'h000)
    else $error("chan status upper bits set");
  a_ctrl_resv: assert property (req.rd && req.addr == LSEC_ADDR_ERR_CTRL
    |=> rdata_r == {12'h000, $past(cnt_sel_r)}) else $error("ctrl read wrong");
  a_align_set: assert property (align_evt ##1 rd_ch |=> rdata_r[4])
    else $error("align flag lost");
  a_coll_set: assert property (lane_evt[0].coll ##1 rd_ch |=> rdata_r[0])
    else $error("collision flag lost");
  a_flag_clear: assert property (rd_ch && !ev_ch ##1 rd_ch |=> rdata_r[4:0] == 5'h00)
    else $error("flag not cleared by read");
  a_drop_set: assert property (lane_evt[3].drop_idle ##1 req.rd
    && req.addr == LSEC_ADDR_SYNC_STATUS |=> rdata_r[15]) else $error("drop flag lost");
  a_sel_write: assert property (req.wr && req.addr == LSEC_ADDR_ERR_CTRL
    |=> cnt_sel_r == $past(req.wdata[3:0])) else $error("select not written");
  a_cnt_keep: assert property (rd_ca && lane_evt[0].disp_err && !cnt_sel_r[0]
    ##1 rd_ca |=> rdata_r == 16'h0001) else $error("error lost at clear");
endmodule
bind lsec_regs lsec_regs_chk lsec_regs_chk_inst (.core_clk(core_clk), .rst_n(rst_n),
  .req(req), .lane_evt(lane_evt), .align_evt(align_evt), .rdata_r(rdata_r),
  .rvalid_r(rvalid_r), .cnt_sel_r(cnt_sel_r));
`default_nettype wire

// *** test_lsec_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_lsec_regs
  import lsec_pkg::*;
();
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  lsec_req_t req;
  lsec_lane_evt_t [3:0] lane_evt = '0;
  logic align_evt = 1'b0;
  logic [15:0] rdata_r;
  logic rvalid_r;
  logic [3:0] cnt_sel_r;
  logic [15:0] exp_q[$];
  logic [15:0] lf = 16'h000b;
  logic [3:0] m;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;
  lsec_host lsec_host_inst (.core_clk(core_clk), .req(req));
  lsec_regs lsec_regs_inst (.core_clk(core_clk), .rst_n(rst_n), .req(req),
    .lane_evt(lane_evt), .align_evt(align_evt), .rdata_r(rdata_r), .rvalid_r(rvalid_r),
    .cnt_sel_r(cnt_sel_r));
  always #2 core_clk = ~core_clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Note the answer, then issue the read
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    lsec_host_inst.put(1'b1, 1'b0, a, 16'h0000);
  endtask
  // One-cycle event pulse on the masked lanes
  task automatic pul(input logic [6:0] f, input logic [3:0] mk);
    @(posedge core_clk);
    for (int i = 0; i < 4; i++) lane_evt[i] <= mk[i] ? f : 7'h00;
    align_evt <= f[6];
    @(posedge core_clk);
    lane_evt <= '0;
    align_evt <= 1'b0;
  endtask
  // Each read answer is compared with the oldest note
  always @(posedge core_clk) begin
    if (rvalid_r === 1'b1) chk("rdata", rdata_r, exp_q.pop_front());
  end
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 80000) begin
      mismatches++;
      report_and_stop();
    end
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    // Reset values over the whole map, including the unmapped word
    for (int i = 0; i < 8; i++) rd(LSEC_ADDR_CHAN_STATUS + 5'(i), 16'h0000);
    lsec_host_inst.put(1'b0, 1'b0, 5'h00, 16'h0000);
    lf = lfsr(lf);
    m = lf[3:0] | 4'h9;
    pul(7'h7c, m);
    rd(LSEC_ADDR_CHAN_STATUS, {11'h000, 1'b1, m});
    rd(LSEC_ADDR_CHAN_STATUS, 16'h0000);
    rd(LSEC_ADDR_SYNC_STATUS, {m, m, m, m});
    rd(LSEC_ADDR_SYNC_STATUS, 16'h0000);
    // Error in the very cycle of the clearing read
    fork
      begin
        rd(LSEC_ADDR_CNT_A, 16'h0000);
        rd(LSEC_ADDR_CNT_A, 16'h0001);
      end
      pul(7'h02, 4'h1);
    join
    lf = lfsr(lf);
    lsec_host_inst.put(1'b0, 1'b1, LSEC_ADDR_ERR_CTRL, lf);
    lsec_host_inst.put(1'b0, 1'b1, LSEC_ADDR_CHAN_STATUS, 16'hffff);
    rd(LSEC_ADDR_ERR_CTRL, {12'h000, lf[3:0]});
    rd(LSEC_ADDR_CHAN_STATUS, 16'h0000);
    lsec_host_inst.put(1'b0, 1'b0, 5'h00, 16'h0000);
    chk("cnt_sel_r", {12'h000, cnt_sel_r}, {12'h000, lf[3:0]});
    repeat (2) pul(7'h02, 4'hf);
    repeat (3) pul(7'h01, 4'hf);
    for (int i = 0; i < 4; i++) rd(LSEC_ADDR_CNT_A + 5'(i), lf[i] ? 16'h3 : 16'h2);
    rd(LSEC_ADDR_CNT_B, 16'h0000);
    lsec_host_inst.put(1'b0, 1'b0, 5'h00, 16'h0000);
    // Errors every cycle past the counter's range
    lane_evt[3] <= 7'h03;
    repeat (65540) @(posedge core_clk);
    lane_evt[3] <= 7'h00;
    rd(LSEC_ADDR_CNT_D, 16'hffff);
    lsec_host_inst.put(1'b0, 1'b0, 5'h00, 16'h0000);
    repeat (3) @(posedge core_clk);
    chk("pending", 16'(exp_q.size()), 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
